// *** dv/ilc_sink.sv ***
// downstream stage model taking vertices from the colour block
// assumes the block's clock and reset; drives only the ready line
`timescale 1ns/1ns
`default_nettype none
module ilc_sink (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic stall_i,
  output logic      ready_o
);
  // ready side handshake
  // toggling while stalled puts back-pressure in mid-stream
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else if (stall_i) begin
      ready_o <= ~ready_o;
    end else begin
      ready_o <= 1'b1;
    end
  end
endmodule // ilc_sink
`default_nettype wire

// *** dv/index_lighting_and_color_clamp_tb.sv ***
// self-checking bench for the index lighting and colour clamp core
// assumes ilc_pkg compiled first and the constants header on the path
`timescale 1ns/1ns
`default_nettype none
`include "ilc_cfg.svh"
module index_lighting_and_color_clamp_tb
  import ilc_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, dat_o, r;
  ilc_vec3_t   scale = {16'sh0100, 16'sh0100, 16'sh0100};
  logic        vin_valid = 1'b0, vin_ready, vout_valid, vout_ready;
  logic        stall = 1'b0;
  ilc_vin_t    vin = '0;
  ilc_vout_t   vout, o;
  ilc_vout_t   q[$];
  int          error_cnt = 0;
  int          total_checks = 0;

  ilc_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .mv_scale_i(scale), .vin_valid_i(vin_valid), .vin_ready_o(vin_ready),
    .vin_data_i(vin), .vout_valid_o(vout_valid),
    .vout_ready_i(vout_ready), .vout_data_o(vout));
  ilc_sink u_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .ready_o(vout_ready));

  // clock, 100 ns period
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // capture every accepted output vertex in order
  always @(posedge clk_i) begin
    if (!rst_i && vout_valid === 1'b1 && vout_ready === 1'b1) begin
      q.push_back(vout);
    end
  end

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  function automatic logic [31:0] sw(int l, int f, int p, int c);
    return (c << `ILC_SEL_COMP_LSB) | (p << `ILC_SEL_PNAME_LSB) |
           (f << `ILC_SEL_FACE_LSB) | l;
  endfunction
  // control word: track mode amb+diff on both faces
  function automatic logic [31:0] cw(int lit, int n, int cl, int two);
    return lit | (two << 2) | 32'h240 | (cl << 12) | (n << 16);
  endfunction
  task automatic lp(int l, int f, int p, int c, logic [31:0] v);
    wb(1'b1, `ILC_ADR_SEL, sw(l, f, p, c));
    wb(1'b1, `ILC_ADR_DATA, v);
  endtask
  task automatic lr(int l, int f, int p, int c);
    wb(1'b1, `ILC_ADR_SEL, sw(l, f, p, c));
    wb(1'b0, `ILC_ADR_DATA, 32'h0);
  endtask
  task automatic one(input ilc_vin_t v);
    int n;
    n = 0;
    @(posedge clk_i);
    vin_valid <= 1'b1;
    vin <= v;
    do @(posedge clk_i); while (vin_ready !== 1'b1);
    vin_valid <= 1'b0;
    while (q.size() == 0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    o = (q.size() != 0) ? q.pop_front() : 'x;
  endtask

  // reset values and stored state
  task automatic t_reset();
    logic [15:0] e[3] = '{16'h0000, 16'h0100, 16'h0100};
    wb(1'b0, `ILC_ADR_CTRL, 32'h0);
    chk("ctrl", 32'h00081240, r);
    wb(1'b0, `ILC_ADR_LIGHT_EN, 32'h0);
    chk("light_en", 32'h0, r);
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 3; c++) begin
        lr(0, f, 4, c);
        chk("triplet", {16'h0, e[c]}, r);
      end
    end
    wb(1'b1, `ILC_ADR_CTRL, 32'h00081132);
    wb(1'b0, `ILC_ADR_CTRL, 32'h0);
    chk("ctrl_store", 32'h00081132, r);
  endtask
  // bad light, face and name, and an unmapped place
  task automatic t_errs();
    logic [31:0] bad[3];
    bad = '{sw(8, 0, 0, 0), sw(0, 2, 4, 0), sw(0, 0, 5, 0)};
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, `ILC_ADR_SEL, bad[i]);
      wb(1'b0, `ILC_ADR_DATA, 32'h0);
      chk("bad_data", 32'h0, r);
      wb(1'b0, `ILC_ADR_STATUS, 32'h0);
      chk("bad_enum", 1'b1, r[0]);
      wb(1'b1, `ILC_ADR_STATUS, 32'h1);
      wb(1'b0, `ILC_ADR_STATUS, 32'h0);
      chk("enum_clr", 1'b0, r[0]);
    end
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, r);
  endtask
  // position and spot axis read back as stored eye values
  task automatic t_pos();
    scale = {16'sh0200, 16'sh0080, 16'sh0100};
    lp(3, 0, 2, 0, 32'h0180);
    lp(3, 0, 2, 1, 32'h0200);
    lp(5, 0, 3, 2, 32'hff00);
    scale = {16'sh0100, 16'sh0100, 16'sh0100};
    lr(3, 0, 2, 0);
    chk("pos_x", 32'h0300, r);
    lr(3, 0, 2, 1);
    chk("pos_y", 32'h0100, r);
    lr(5, 0, 3, 2);
    chk("spot_z", 32'hffffff00, r);
  endtask
  // index lighting: kd0 kd1 ks0 two-side back-facing expected
  task automatic t_light();
    logic [15:0] tb[4][6];
    ilc_vin_t v;
    tb = '{'{16'h80, 16'h100, 16'h0, 0, 0, 16'h0200},
           '{16'h300, 16'h100, 16'h0, 0, 0, 16'h0400},
           '{16'h200, 16'h0, 16'h200, 0, 0, 16'h0400},
           '{16'h300, 16'h0, 16'h0, 1, 1, 16'h0200}};
    for (int l = 0; l < 8; l++) begin
      for (int c = 0; c < 6; c++) begin
        lp(l, 0, c / 3, c % 3, (l < 2 && c < 3) || (l == 0) ? 32'h100 : 0);
      end
    end
    for (int c = 0; c < 3; c++) begin
      lp(0, 0, 4, c, c == 0 ? 32'h100 : c == 1 ? 32'h300 : 32'h400);
      lp(0, 1, 4, c, c == 0 ? 32'h100 : c == 1 ? 32'h300 : 32'h200);
    end
    wb(1'b1, `ILC_ADR_LIGHT_EN, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `ILC_ADR_CTRL, cw(1, 8, 1, tb[i][3]));
      v = '0;
      v.ci_mode = 1'b1;
      v.back_facing = tb[i][4][0];
      v.kd[0] = tb[i][0];
      v.kd[1] = tb[i][1];
      v.ks[0] = tb[i][2];
      one(v);
      chk("ci_index", tb[i][5], o.index);
    end
  endtask
  // index masking with lighting off, then RGBA clamp modes
  task automatic t_clamp();
    ilc_vin_t v;
    v = '0;
    v.ci_mode = 1'b1;
    v.index = 16'h0580;
    wb(1'b1, `ILC_ADR_CTRL, cw(0, 2, 1, 0));
    one(v);
    chk("mask_n2", 16'h0180, o.index);
    v = '0;
    v.pri = {16'h0180, 16'hffc0, 16'h0080, 16'h0100};
    v.sec = {16'hfe00, 16'h0300, 16'h00ff, 16'h0000};
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, `ILC_ADR_CTRL, cw(1, 8, m, 0));
      one(v);
      chk("pri", m ? 64'h0100000000800100 : v.pri, o.pri);
      chk("sec", m ? 64'h0000010000ff0000 : v.sec, o.sec);
    end
  endtask
  // back-to-back vertices against a stalling sink keep their order
  task automatic t_stream();
    ilc_vin_t v;
    v = '0;
    v.ci_mode = 1'b1;
    wb(1'b1, `ILC_ADR_CTRL, cw(0, 8, 1, 0));
    stall <= 1'b1;
    @(posedge clk_i);
    vin_valid <= 1'b1;
    for (int k = 1; k < 7; k++) begin
      v.index = 16'(k * 256 + 16);
      vin <= v;
      do @(posedge clk_i); while (vin_ready !== 1'b1);
    end
    vin_valid <= 1'b0;
    stall <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("count", 6, q.size());
    for (int k = 1; k < 7; k++) begin
      o = (q.size() != 0) ? q.pop_front() : 'x;
      chk("order", 16'(k * 256 + 16), o.index);
    end
    chk("drained", 1'b0, vout_valid);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // about 550 cycles of traffic expected; allow over twenty-five times that
  initial begin
    #1500000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_errs();
    t_pos();
    t_light();
    t_clamp();
    t_stream();
    give_verdict();
  end
endmodule // index_lighting_and_color_clamp_tb
`default_nettype wire

// *** pkg/ilc_cfg.svh ***
// constants for the index lighting and colour clamp block
// assumes Q8.8 signed fixed point and a 32-bit classic bus slave
`ifndef ILC_CFG_SVH
`define ILC_CFG_SVH

`define ILC_NUM_LIGHTS     8
`define ILC_SLOTS          12
// register byte addresses
`define ILC_ADR_CTRL       8'h00
`define ILC_ADR_LIGHT_EN   8'h04
`define ILC_ADR_STATUS     8'h08
`define ILC_ADR_SEL        8'h0c
`define ILC_ADR_DATA       8'h10
// control field positions
`define ILC_CTRL_LIGHT_BIT 0
`define ILC_CTRL_TRACK_BIT 1
`define ILC_CTRL_TWO_BIT   2
`define ILC_CTRL_MODE_LSB  4
`define ILC_CTRL_FACE_LSB  8
`define ILC_CTRL_CLAMP_LSB 12
`define ILC_CTRL_NBITS_LSB 16
// selector field positions
`define ILC_SEL_LIGHT_LSB  0
`define ILC_SEL_FACE_LSB   4
`define ILC_SEL_PNAME_LSB  8
`define ILC_SEL_COMP_LSB   12
// reset values
`define ILC_RST_NBITS      4'h8
`define ILC_RST_LIGHT_EN   8'h00
`define ILC_RST_AM         16'h0000
`define ILC_RST_DM         16'h0100
`define ILC_RST_SM         16'h0100
// arithmetic constants
`define ILC_ONE            32'sh00000100
`define ILC_W_R            32'sh0000004d
`define ILC_W_G            32'sh00000097
`define ILC_W_B            32'sh0000001c
`define ILC_ROUND          64'sh0000000000000080

`endif

// *** pkg/ilc_pkg.sv ***
// types shared by the index lighting and colour clamp block
// assumes the constants header is on the include path
`include "ilc_cfg.svh"
package ilc_pkg;
  typedef logic signed [15:0] ilc_fx_t;
  typedef enum logic [2:0] {ILC_TRK_EMIT = 3'h0, ILC_TRK_AMB = 3'h1,
    ILC_TRK_DIFF = 3'h2, ILC_TRK_SPEC = 3'h3,
    ILC_TRK_AMB_DIFF = 3'h4} ilc_track_t;
  typedef enum logic [1:0] {ILC_FACE_FRONT = 2'h0, ILC_FACE_BACK = 2'h1,
    ILC_FACE_BOTH = 2'h2} ilc_face_t;
  typedef enum logic [1:0] {ILC_CLAMP_OFF = 2'h0, ILC_CLAMP_ON = 2'h1,
    ILC_CLAMP_FIXED = 2'h2} ilc_clamp_t;
  typedef enum logic [2:0] {ILC_PN_DIFF = 3'h0, ILC_PN_SPEC = 3'h1,
    ILC_PN_POS = 3'h2, ILC_PN_SPOT = 3'h3,
    ILC_PN_INDEX = 3'h4} ilc_pname_t;
  typedef struct packed {ilc_fx_t r; ilc_fx_t g; ilc_fx_t b; ilc_fx_t a;}
    ilc_rgba_t;
  typedef struct packed {ilc_fx_t x; ilc_fx_t y; ilc_fx_t z;} ilc_vec3_t;
  typedef struct packed {
    logic                            ci_mode;
    logic                            back_facing;
    ilc_rgba_t                       pri;
    ilc_rgba_t                       sec;
    ilc_fx_t                         index;
    ilc_fx_t [`ILC_NUM_LIGHTS-1:0]   kd;
    ilc_fx_t [`ILC_NUM_LIGHTS-1:0]   ks;
  } ilc_vin_t;
  typedef struct packed {
    logic      ci_mode;
    ilc_rgba_t pri;
    ilc_rgba_t sec;
    ilc_fx_t   index;
  } ilc_vout_t;
endpackage

// *** rtl/ilc_core.sv ***
// index lighting, colour clamp and lighting state with bus slave
// assumes upstream supplies per-light att*spot*geometry factors
// Operation
// [RULE1] position and spot axis read back as eye-space values stored at write
// [RULE2] reads reject bad selector, face or name like writes do
// [RULE3] light selector valid only from zero to light count minus one
// [RULE4] material read face must be front or back only
// [RULE5] hold eight light sets, eight enables, front and back material
// [RULE6] store five-valued tracking mode, tracking, lighting, two-side bits
// [RULE7] reset: two-side off, tracking both faces ambient+diffuse, all off
// [RULE8] index intensities are .30R+.59G+.11B of diffuse and specular
// [RULE9] index value am + d(1-s')(dm-am) + s'(sm-am), s' limited to one
// [RULE10] final index is the smaller of computed value and sm
// [RULE11] no separate ambient term; ambient folded into am
// [RULE12] disabled lights dropped from both sums
// [RULE13] two-sided front/back selection as for RGBA lighting
// [RULE14] index material resets to 0, 1, 1; written as a triplet
// [RULE15] index material never affects RGBA results
// [RULE16] clamp RGBA primary and secondary to [0,1] when enabled
// [RULE17] index converted to nearest fixed point keeping fraction
// [RULE18] integer part of index masked with 2^n - 1
// [RULE19] clamp control is three-valued, resets to true
// [RULE20] third clamp value behaves as clamp enabled
// [RULE21] vertices pass by valid/ready, one per transfer, in order
// [RULE22] Q8.8 precision, rounded products, saturating narrowing
`timescale 1ns/1ns
`default_nettype none
module ilc_core
  import ilc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire ilc_vec3_t   mv_scale_i,
  input  wire logic        vin_valid_i,
  output logic             vin_ready_o,
  input  wire ilc_vin_t    vin_data_i,
  output logic             vout_valid_o,
  input  wire logic        vout_ready_i,
  output ilc_vout_t        vout_data_o
);
  // rounded Q8.8 product, nearest value
  function automatic logic signed [31:0] fx_mul(
    input logic signed [31:0] a, input logic signed [31:0] b);
    logic signed [63:0] p;
    p = 64'(a) * 64'(b) + `ILC_ROUND;
    fx_mul = 32'(p >>> 8);
  endfunction

  // saturating narrowing to 16 bits
  function automatic ilc_fx_t fx_sat(input logic signed [31:0] v);
    if (v > 32'sh00007fff) fx_sat = 16'h7fff;
    else if (v < -32'sh00008000) fx_sat = 16'h8000;
    else fx_sat = v[15:0];
  endfunction

  // [RULE8] luminance weighting
  function automatic logic signed [31:0] fx_lum(
    input ilc_fx_t r, input ilc_fx_t g, input ilc_fx_t b);
    fx_lum = fx_mul(32'(r), `ILC_W_R) + fx_mul(32'(g), `ILC_W_G)
           + fx_mul(32'(b), `ILC_W_B);
  endfunction

  function automatic ilc_fx_t fx_unit(input ilc_fx_t v);
    if (v < 16'sh0000) fx_unit = 16'h0000;
    else if (v > 16'sh0100) fx_unit = 16'h0100;
    else fx_unit = v;
  endfunction

  function automatic ilc_rgba_t rgba_clamp(input ilc_rgba_t c,
                                           input logic en);
    rgba_clamp = en ? '{fx_unit(c.r), fx_unit(c.g), fx_unit(c.b),
                        fx_unit(c.a)} : c;
  endfunction

  function automatic logic [7:0] int_mask(input logic [3:0] n);
    int_mask = ~8'(8'hff << n);
  endfunction

  // storage slot of a light parameter component
  function automatic logic [3:0] slot_of(input logic [2:0] pn,
                                         input logic [1:0] comp);
    slot_of = 4'({1'b0, pn} * 4'h3 + {2'h0, comp});
  endfunction

  // lighting state
  logic                    lighting_en;
  logic                    track_en;
  logic                    two_side;
  ilc_track_t              track_mode;
  ilc_face_t               track_face;
  ilc_clamp_t              clamp_mode;
  logic [3:0]              idx_bits;
  logic [7:0]              light_en;
  logic [15:0]             psel;
  logic                    bad_enum;
  ilc_fx_t                 light_par [`ILC_NUM_LIGHTS][`ILC_SLOTS];
  ilc_fx_t                 mat_idx [2][3];

  // bus decode
  logic        req;
  logic        wr;
  logic        rd;
  logic        hit_data;
  logic [3:0]  sel_light;
  ilc_face_t   sel_face;
  ilc_pname_t  sel_pname;
  logic [1:0]  sel_comp;
  logic        is_mat;
  logic        base_ok;
  logic        ok_wr;
  logic        ok_rd;
  logic [3:0]  slot;
  logic [31:0] wmerge;
  ilc_fx_t     wval;
  ilc_fx_t     pos_scaled;
  ilc_fx_t     mv_comp;

  assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr        = req & wb_we_i;
  assign rd        = req & ~wb_we_i;
  assign hit_data  = wb_adr_i == `ILC_ADR_DATA;
  assign sel_light = psel[`ILC_SEL_LIGHT_LSB +: 4];
  assign sel_face  = ilc_face_t'(psel[`ILC_SEL_FACE_LSB +: 2]);
  assign sel_pname = ilc_pname_t'(psel[`ILC_SEL_PNAME_LSB +: 3]);
  assign sel_comp  = psel[`ILC_SEL_COMP_LSB +: 2];
  assign is_mat    = sel_pname == ILC_PN_INDEX;
  assign slot      = slot_of(sel_pname, sel_comp);
  // [RULE3] light selector range and name check
  assign base_ok   = (sel_pname <= ILC_PN_INDEX) && (sel_comp < 2'h3)
                   && (is_mat || sel_light < 4'(`ILC_NUM_LIGHTS));
  assign ok_wr     = base_ok && (!is_mat || sel_face <= ILC_FACE_BOTH);
  // [RULE4] read selects exactly one face
  assign ok_rd     = base_ok && (!is_mat || sel_face <= ILC_FACE_BACK);

  // byte-lane merge of a write with the current value
  always_comb begin
    wmerge = 32'(light_par[sel_light[2:0]][slot]);
    if (is_mat) wmerge = 32'(mat_idx[sel_face[0]][sel_comp]);
    for (int i = 0; i < 4; i++) begin
      if (wb_sel_i[i]) wmerge[8*i +: 8] = wb_dat_i[8*i +: 8];
    end
  end
  assign wval = wmerge[15:0];

  // [RULE1] eye-space transform done once, when written
  always_comb begin
    case (sel_comp)
      2'h0:    mv_comp = mv_scale_i.x;
      2'h1:    mv_comp = mv_scale_i.y;
      default: mv_comp = mv_scale_i.z;
    endcase
  end
  assign pos_scaled = fx_sat(fx_mul(32'(wval), 32'(mv_comp)));

  // bus acknowledge, one cycle after a request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= req;
  end

  // [RULE6] control register, [RULE7] reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lighting_en <= 1'b0;
      track_en    <= 1'b0;
      two_side    <= 1'b0;
      track_mode  <= ILC_TRK_AMB_DIFF;
      track_face  <= ILC_FACE_BOTH;
      clamp_mode  <= ILC_CLAMP_ON; // [RULE19] three-valued, true at reset
      idx_bits    <= `ILC_RST_NBITS;
    end else if (wr && wb_adr_i == `ILC_ADR_CTRL) begin
      if (wb_sel_i[0]) begin
        lighting_en <= wb_dat_i[`ILC_CTRL_LIGHT_BIT];
        track_en    <= wb_dat_i[`ILC_CTRL_TRACK_BIT];
        two_side    <= wb_dat_i[`ILC_CTRL_TWO_BIT];
        // out-of-range mode codes are dropped, keeping five values
        if (wb_dat_i[`ILC_CTRL_MODE_LSB +: 3] <= 3'(ILC_TRK_AMB_DIFF))
          track_mode <= ilc_track_t'(wb_dat_i[`ILC_CTRL_MODE_LSB +: 3]);
      end
      if (wb_sel_i[1]) begin
        if (wb_dat_i[`ILC_CTRL_FACE_LSB +: 2] <= 2'(ILC_FACE_BOTH))
          track_face <= ilc_face_t'(wb_dat_i[`ILC_CTRL_FACE_LSB +: 2]);
        if (wb_dat_i[`ILC_CTRL_CLAMP_LSB +: 2] <= 2'(ILC_CLAMP_FIXED))
          clamp_mode <= ilc_clamp_t'(wb_dat_i[`ILC_CTRL_CLAMP_LSB +: 2]);
      end
      if (wb_sel_i[2]) idx_bits <= wb_dat_i[`ILC_CTRL_NBITS_LSB +: 4];
    end
  end

  // [RULE5] per-light enables and selector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      light_en <= `ILC_RST_LIGHT_EN;
      psel     <= 16'h0000;
    end else if (wr) begin
      if (wb_adr_i == `ILC_ADR_LIGHT_EN && wb_sel_i[0])
        light_en <= wb_dat_i[7:0];
      if (wb_adr_i == `ILC_ADR_SEL) begin
        if (wb_sel_i[0]) psel[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) psel[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // [RULE2] bad access sets the sticky flag; set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) bad_enum <= 1'b0;
    else if (hit_data && ((wr && !ok_wr) || (rd && !ok_rd)))
      bad_enum <= 1'b1;
    else if (wr && wb_adr_i == `ILC_ADR_STATUS && wb_sel_i[0]
             && wb_dat_i[0])
      bad_enum <= 1'b0;
  end

  // [RULE5] eight light parameter sets; no reset needed for data
  always_ff @(posedge clk_i) begin
    if (wr && hit_data && ok_wr && !is_mat) begin
      if (sel_pname == ILC_PN_POS || sel_pname == ILC_PN_SPOT)
        light_par[sel_light[2:0]][slot] <= pos_scaled;
      else
        light_par[sel_light[2:0]][slot] <= wval;
    end
  end

  // [RULE14] index material triplet, 0/1/1 at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int f = 0; f < 2; f++) begin
        mat_idx[f][0] <= `ILC_RST_AM;
        mat_idx[f][1] <= `ILC_RST_DM;
        mat_idx[f][2] <= `ILC_RST_SM;
      end
    end else if (wr && hit_data && ok_wr && is_mat) begin
      if (sel_face != ILC_FACE_BACK) mat_idx[0][sel_comp] <= wval;
      if (sel_face != ILC_FACE_FRONT) mat_idx[1][sel_comp] <= wval;
    end
  end

  // read data; unmapped and refused reads answer zero
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_dat_o <= 32'h00000000;
    else if (rd) begin
      case (wb_adr_i)
        `ILC_ADR_CTRL: wb_dat_o <= {12'h000, idx_bits, 2'h0, clamp_mode,
                         2'h0, track_face, 1'b0, track_mode, 1'b0,
                         two_side, track_en, lighting_en};
        `ILC_ADR_LIGHT_EN: wb_dat_o <= {24'h000000, light_en};
        `ILC_ADR_STATUS:   wb_dat_o <= {31'h00000000, bad_enum};
        `ILC_ADR_SEL:      wb_dat_o <= {16'h0000, psel};
        // [RULE2] refused read returns zero
        `ILC_ADR_DATA: begin
          if (!ok_rd) wb_dat_o <= 32'h00000000;
          else if (is_mat)
            wb_dat_o <= 32'(mat_idx[sel_face[0]][sel_comp]);
          else wb_dat_o <= 32'(light_par[sel_light[2:0]][slot]);
        end
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // index lighting datapath, one vertex per cycle
  logic signed [31:0] s_sum;
  logic signed [31:0] d_sum;
  logic signed [31:0] s_sat;
  logic signed [31:0] am;
  logic signed [31:0] dm;
  logic signed [31:0] sm;
  logic signed [31:0] c_val;
  logic signed [31:0] c_fin;
  logic               use_back;
  logic               clamp_on;
  logic               in_fire;
  ilc_fx_t            ci_src;
  ilc_vout_t          next_vout;

  always_comb begin
    s_sum = 32'sh00000000;
    d_sum = 32'sh00000000;
    for (int i = 0; i < `ILC_NUM_LIGHTS; i++) begin
      // [RULE12] disabled lights drop out of both sums
      if (light_en[i]) begin
        s_sum = s_sum + fx_mul(32'(vin_data_i.ks[i]),
          fx_lum(light_par[i][3], light_par[i][4], light_par[i][5]));
        d_sum = d_sum + fx_mul(32'(vin_data_i.kd[i]),
          fx_lum(light_par[i][0], light_par[i][1], light_par[i][2]));
      end
    end
  end

  // [RULE13] back material only for back faces with two-side on
  assign use_back = two_side & vin_data_i.back_facing;
  assign am = 32'(mat_idx[use_back][0]);
  assign dm = 32'(mat_idx[use_back][1]);
  assign sm = 32'(mat_idx[use_back][2]);
  // [RULE9] specular sum limited to one
  assign s_sat = (s_sum > `ILC_ONE) ? `ILC_ONE : s_sum;
  // [RULE11] ambient lighting lives only inside am
  assign c_val = am + fx_mul(fx_mul(d_sum, `ILC_ONE - s_sat), dm - am)
               + fx_mul(s_sat, sm - am);
  // [RULE10] final index no larger than sm
  assign c_fin = (c_val < sm) ? c_val : sm;
  // [RULE20] the third setting clamps like true in this datapath
  assign clamp_on = clamp_mode != ILC_CLAMP_OFF;
  // [RULE17] products round to nearest Q8.8; fraction kept
  assign ci_src = lighting_en ? fx_sat(c_fin) : vin_data_i.index;

  always_comb begin
    next_vout.ci_mode = vin_data_i.ci_mode;
    // [RULE15] RGBA path never reads the index material
    // [RULE16] clamp primary and secondary when enabled
    next_vout.pri = vin_data_i.ci_mode ? vin_data_i.pri
                  : rgba_clamp(vin_data_i.pri, clamp_on);
    next_vout.sec = vin_data_i.ci_mode ? vin_data_i.sec
                  : rgba_clamp(vin_data_i.sec, clamp_on);
    // [RULE18] integer part masked to buffer width
    next_vout.index = {ci_src[15:8] & int_mask(idx_bits), ci_src[7:0]};
  end

  // [RULE21] single output stage keeps order and holds under stall
  assign vin_ready_o = ~vout_valid_o | vout_ready_i;
  assign in_fire     = vin_valid_i & vin_ready_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) vout_valid_o <= 1'b0;
    else if (in_fire) vout_valid_o <= 1'b1;
    else if (vout_ready_i) vout_valid_o <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) vout_data_o <= '0;
    else if (in_fire) vout_data_o <= next_vout;
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_pos_write;
    wr && hit_data && ok_wr && sel_pname == ILC_PN_POS;
  endsequence

  a_ack_one_pulse: assert property (s_bus_req |=> s_ack_pulse) // bus ack, one pulse per request
    else $error("bus ack not a single pulse after request");
  a_reset_state: assert property ($past(rst_i) |-> !two_side // [RULE7]
      && !lighting_en && !track_en && track_mode == ILC_TRK_AMB_DIFF
      && track_face == ILC_FACE_BOTH && clamp_mode == ILC_CLAMP_ON)
    else $error("lighting state wrong after reset");
  a_bad_light_flag: assert property (wr && hit_data && !is_mat // [RULE3]
      && sel_light >= 4'(`ILC_NUM_LIGHTS) |=> bad_enum)
    else $error("bad light selector not flagged");
  a_read_face_both: assert property (rd && hit_data && is_mat // [RULE4]
      && sel_face == ILC_FACE_BOTH |=> wb_dat_o == 32'h0 && bad_enum)
    else $error("material read with both faces not refused");
  a_pos_eye_store: assert property (s_pos_write |=> // [RULE1]
      light_par[$past(sel_light[2:0])][$past(slot)] == $past(pos_scaled))
    else $error("position not stored in eye space");
  a_spec_limit: assert property (vin_valid_i |-> s_sat <= `ILC_ONE // [RULE9]
      && (s_sum > `ILC_ONE || s_sat == s_sum))
    else $error("specular sum not limited to one");
  a_index_min: assert property (vin_valid_i |-> c_fin <= sm // [RULE10]
      && (c_fin == c_val || c_fin == sm))
    else $error("final index exceeds specular index");
  a_light_off: assert property (light_en == 8'h00 // [RULE12]
      |-> s_sum == 32'sh0 && d_sum == 32'sh0)
    else $error("disabled light contributed");
  a_clamp_unit: assert property (in_fire && !vin_data_i.ci_mode // [RULE16]
      && clamp_on |=> vout_data_o.pri == rgba_clamp(vout_data_o.pri, 1'b1)
      && vout_data_o.sec == rgba_clamp(vout_data_o.sec, 1'b1))
    else $error("clamped colour outside unit range");
  a_index_mask: assert property (in_fire && vin_data_i.ci_mode // [RULE18]
      |=> (vout_data_o.index[15:8] & ~$past(int_mask(idx_bits))) == 8'h0)
    else $error("index integer bits not masked");
  a_hold_stall: assert property (vout_valid_o && !vout_ready_i // [RULE21]
      |=> vout_valid_o && $stable(vout_data_o))
    else $error("output vertex changed while stalled");
endmodule // ilc_core
`default_nettype wire
